// ### logic/fsfwe_pkg.sv
package fsfwe_pkg;
  localparam int DATA_W = 9;
  localparam int DEF_DEPTH = 256;
  localparam int NUM_DEV = 2;
  localparam int BUF_DEPTH = 16;
  localparam int OFS_REG_W = 8;
  localparam int OFS_JOIN_W = 2 * OFS_REG_W;
  localparam int NUM_OFS_REGS = 4;
  // Offset register order in the load sequence
  localparam logic [1:0] OFS_EMPTY_LSB = 2'h0;
  localparam logic [1:0] OFS_EMPTY_MSB = 2'h1;
  localparam logic [1:0] OFS_FULL_LSB = 2'h2;
  localparam logic [1:0] OFS_FULL_MSB = 2'h3;
  localparam logic [1:0] OFS_SEL_STEP = 2'h1;
  localparam logic [7:0] OFS_DEFAULT_LSB = 8'h07;
  localparam logic [7:0] OFS_DEFAULT_MSB = 8'h00;
  localparam logic [3:0] RESET_HOLD_CYCLES = 4'h2;
  localparam logic [3:0] HOLD_STEP = 4'h1;
endpackage

// ### logic/fsfwe_if.sv
`timescale 1ns/1ps
interface fsfwe_if #(
  parameter int NDEV = fsfwe_pkg::NUM_DEV
);
  logic [NDEV*fsfwe_pkg::DATA_W-1:0] wrData;
  logic [NDEV*fsfwe_pkg::DATA_W-1:0] rdData;
  logic wen1N;
  logic wen2Ld;
  logic ren1N;
  logic ren2N;
  logic masterResetN;
  logic [NDEV-1:0] fullFlagN;
  logic [NDEV-1:0] emptyFlagN;
  logic [NDEV-1:0] almostEmptyFlagN;
  logic [NDEV-1:0] almostFullFlagN;

  modport device (
    input wrData,
    input wen1N,
    input wen2Ld,
    input ren1N,
    input ren2N,
    input masterResetN,
    output rdData,
    output fullFlagN,
    output emptyFlagN,
    output almostEmptyFlagN,
    output almostFullFlagN
  );

  modport system (
    output wrData,
    output wen1N,
    output wen2Ld,
    output ren1N,
    output ren2N,
    output masterResetN,
    input rdData,
    input fullFlagN,
    input emptyFlagN,
    input almostEmptyFlagN,
    input almostFullFlagN
  );
endinterface

// ### logic/fsfwe_stream_buffer.sv
`timescale 1ns/1ps
module fsfwe_stream_buffer #(
  parameter int WIDTH = fsfwe_pkg::DATA_W,
  parameter int DEPTH = fsfwe_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] headPtr;
  logic [AW-1:0] tailPtr;
  logic [AW:0] used;

  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = used != CNT_FULL;
  assign outValid = used != '0;
  assign outData = store[tailPtr];

  always_ff @(posedge clk) begin
    if (push) begin
      store[headPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      headPtr <= '0;
      tailPtr <= '0;
      used <= '0;
    end else begin
      if (push) begin
        headPtr <= (headPtr == AW'(DEPTH - 1)) ? '0 : headPtr + PTR_ONE;
      end
      if (pop) begin
        tailPtr <= (tailPtr == AW'(DEPTH - 1)) ? '0 : tailPtr + PTR_ONE;
      end
      if (push && !pop) begin
        used <= used + CNT_ONE;
      end else if (pop && !push) begin
        used <= used - CNT_ONE;
      end
    end
  end
endmodule

// ### logic/fsfwe_system.sv
`timescale 1ns/1ps
module fsfwe_system #(
  parameter int NDEV = fsfwe_pkg::NUM_DEV,
  parameter int BUF_DEPTH = fsfwe_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  fsfwe_if.system link,
  input wire logic inValid,
  output logic inReady,
  input wire logic [NDEV*fsfwe_pkg::DATA_W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [NDEV*fsfwe_pkg::DATA_W-1:0] outData,
  output logic almostEmptyN,
  output logic almostFullN,
  output logic running
);
  localparam int WW = NDEV * fsfwe_pkg::DATA_W;

  typedef enum logic {SYS_RESET, SYS_RUN} fsfwe_sys_e;

  fsfwe_sys_e state;
  logic [3:0] holdCnt;
  logic readPend;
  logic bufValid;
  logic [WW-1:0] bufData;

  // Any device full or empty flag low blocks the whole wide word
  wire compositeFullN = &link.fullFlagN;
  wire compositeEmptyN = &link.emptyFlagN;
  wire bufReady = running && compositeFullN;
  wire doWrite = bufValid && bufReady;
  wire doRead = running && compositeEmptyN && !readPend && (!outValid || outReady);

  fsfwe_stream_buffer #(
    .WIDTH(WW),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(inValid),
    .inReady(inReady),
    .inData(inData),
    .outValid(bufValid),
    .outReady(bufReady),
    .outData(bufData)
  );

  assign running = state == SYS_RUN;
  // Common controls drive every device in lockstep
  assign link.masterResetN = running;
  assign link.wen2Ld = running;
  assign link.wen1N = !doWrite;
  assign link.wrData = bufData;
  assign link.ren1N = !doRead;
  assign link.ren2N = 1'b0;
  assign almostEmptyN = link.almostEmptyFlagN[0];
  assign almostFullN = link.almostFullFlagN[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SYS_RESET;
      holdCnt <= '0;
    end else begin
      case (state)
        SYS_RESET: begin
          holdCnt <= holdCnt + fsfwe_pkg::HOLD_STEP;
          if (holdCnt == fsfwe_pkg::RESET_HOLD_CYCLES - fsfwe_pkg::HOLD_STEP) begin
            state <= SYS_RUN;
          end
        end
        SYS_RUN: begin
          state <= SYS_RUN;
        end
        default: begin
          state <= SYS_RESET;
        end
      endcase
    end
  end

  // Read data arrives the cycle after the read edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readPend <= 1'b0;
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      readPend <= doRead;
      if (readPend) begin
        outValid <= 1'b1;
        outData <= link.rdData;
      end else if (outValid && outReady) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule

// ### logic/fsfwe_device.sv
// Function
// - System drives all device controls from common signals
// - System merges full flags and empty flags
// - Almost flags taken from any one device
// - Two devices form 18 bits, more widen
// - Second read enable may be tied low
// - Load pin held low during master reset
// - Four status flags, all clocked
// - Full flag low when every location holds
// - Writes ignored while full flag low
// - Full flag changes only on write clock
// - Empty flag low when nothing unread
// - Reads ignored while empty flag low
// - Empty flag changes only on read clock
// - Almost-empty low at n or fewer words
// - Almost-full low at depth minus m words
// - Both offsets default to seven
// - High load pin at reset gives write enable
`timescale 1ns/1ps
module fsfwe_device #(
  parameter int DEPTH = fsfwe_pkg::DEF_DEPTH,
  parameter int IDX = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  fsfwe_if.device link,
  output logic [$clog2(DEPTH):0] wordCount
);
  localparam int DW = fsfwe_pkg::DATA_W;
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [PW:0] CNT_ONE = (PW+1)'(1);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
  localparam int OW = fsfwe_pkg::OFS_REG_W;

  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic [DW-1:0] rdDataQ;
  logic fullFlagN;
  logic emptyFlagN;
  logic almostEmptyFlagN;
  logic almostFullFlagN;
  logic loadMode;
  logic [OW-1:0] ofs [fsfwe_pkg::NUM_OFS_REGS];
  logic [1:0] ofsWrSel;
  logic [1:0] ofsRdSel;

  function automatic logic [PW:0] joinOffset(input logic [OW-1:0] lsb,
                                              input logic [OW-1:0] msb);
    logic [fsfwe_pkg::OFS_JOIN_W-1:0] v;
    v = {msb, lsb};
    joinOffset = v[PW:0];
  endfunction

  function automatic logic [1:0] nextSel(input logic [1:0] sel);
    nextSel = sel + fsfwe_pkg::OFS_SEL_STEP;
  endfunction

  // Load pin low in load mode steers transfers to the offset registers
  wire ofsAccess = loadMode && !link.wen2Ld;
  wire readReq = !link.ren1N && !link.ren2N;
  wire writeReq = !link.wen1N && link.wen2Ld;
  wire doWrite = writeReq && fullFlagN;
  wire doRead = readReq && emptyFlagN && !ofsAccess;
  wire ofsWrite = ofsAccess && !link.wen1N;
  wire ofsRead = ofsAccess && readReq && !ofsWrite;
  wire inReset = !link.masterResetN;

  wire [PW:0] emptyOfs = joinOffset(ofs[fsfwe_pkg::OFS_EMPTY_LSB],
                                    ofs[fsfwe_pkg::OFS_EMPTY_MSB]);
  wire [PW:0] fullOfs = joinOffset(ofs[fsfwe_pkg::OFS_FULL_LSB],
                                   ofs[fsfwe_pkg::OFS_FULL_MSB]);

  wire [PW:0] next_count = (doWrite && !doRead) ? count + CNT_ONE :
                           (doRead && !doWrite) ? count - CNT_ONE : count;
  wire [PW:0] freeSlots = CNT_FULL - next_count;

  assign wordCount = count;
  assign link.rdData[IDX*DW +: DW] = rdDataQ;
  assign link.fullFlagN[IDX] = fullFlagN;
  assign link.emptyFlagN[IDX] = emptyFlagN;
  assign link.almostEmptyFlagN[IDX] = almostEmptyFlagN;
  assign link.almostFullFlagN[IDX] = almostFullFlagN;

  always_ff @(posedge clk) begin
    if (doWrite && !inReset) begin
      mem[wrPtr] <= link.wrData[IDX*DW +: DW];
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (inReset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + PTR_ONE;
      end
      if (doRead) begin
        rdPtr <= rdPtr + PTR_ONE;
      end
      count <= next_count;
    end
  end

  // Status flags, registered from the coming fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fullFlagN <= 1'b1;
      emptyFlagN <= 1'b0;
      almostEmptyFlagN <= 1'b0;
      almostFullFlagN <= 1'b1;
    end else if (inReset) begin
      fullFlagN <= 1'b1;
      emptyFlagN <= 1'b0;
      almostEmptyFlagN <= 1'b0;
      almostFullFlagN <= 1'b1;
    end else begin
      fullFlagN <= next_count != CNT_FULL;
      emptyFlagN <= next_count != '0;
      almostEmptyFlagN <= next_count > emptyOfs;
      almostFullFlagN <= freeSlots > fullOfs;
    end
  end

  // Pin role caught while master reset is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loadMode <= 1'b1;
    end else if (inReset) begin
      loadMode <= !link.wen2Ld;
    end
  end

  // Offset registers, written and read in a rotating sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ofs[fsfwe_pkg::OFS_EMPTY_LSB] <= fsfwe_pkg::OFS_DEFAULT_LSB;
      ofs[fsfwe_pkg::OFS_EMPTY_MSB] <= fsfwe_pkg::OFS_DEFAULT_MSB;
      ofs[fsfwe_pkg::OFS_FULL_LSB] <= fsfwe_pkg::OFS_DEFAULT_LSB;
      ofs[fsfwe_pkg::OFS_FULL_MSB] <= fsfwe_pkg::OFS_DEFAULT_MSB;
      ofsWrSel <= fsfwe_pkg::OFS_EMPTY_LSB;
      ofsRdSel <= fsfwe_pkg::OFS_EMPTY_LSB;
    end else if (inReset) begin
      ofs[fsfwe_pkg::OFS_EMPTY_LSB] <= fsfwe_pkg::OFS_DEFAULT_LSB;
      ofs[fsfwe_pkg::OFS_EMPTY_MSB] <= fsfwe_pkg::OFS_DEFAULT_MSB;
      ofs[fsfwe_pkg::OFS_FULL_LSB] <= fsfwe_pkg::OFS_DEFAULT_LSB;
      ofs[fsfwe_pkg::OFS_FULL_MSB] <= fsfwe_pkg::OFS_DEFAULT_MSB;
      ofsWrSel <= fsfwe_pkg::OFS_EMPTY_LSB;
      ofsRdSel <= fsfwe_pkg::OFS_EMPTY_LSB;
    end else begin
      if (ofsWrite) begin
        ofs[ofsWrSel] <= link.wrData[IDX*DW +: OW];
        ofsWrSel <= nextSel(ofsWrSel);
      end
      if (ofsRead) begin
        ofsRdSel <= nextSel(ofsRdSel);
      end
    end
  end

  // Output word holds the last read until another read or a master reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataQ <= '0;
    end else if (inReset) begin
      rdDataQ <= '0;
    end else if (doRead) begin
      rdDataQ <= mem[rdPtr];
    end else if (ofsRead) begin
      rdDataQ <= {{(DW-OW){1'b0}}, ofs[ofsRdSel]};
    end
  end
endmodule

// ### testbench/fsfwe_link_props.sv
`timescale 1ns/1ps
module fsfwe_link_props #(
  parameter int NDEV = fsfwe_pkg::NUM_DEV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [NDEV*fsfwe_pkg::DATA_W-1:0] rdData,
  input wire logic wen1N,
  input wire logic wen2Ld,
  input wire logic ren1N,
  input wire logic ren2N,
  input wire logic masterResetN,
  input wire logic [NDEV-1:0] fullFlagN,
  input wire logic [NDEV-1:0] emptyFlagN,
  input wire logic [NDEV-1:0] almostEmptyFlagN,
  input wire logic [NDEV-1:0] almostFullFlagN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_no_write_full: assert property (!(&fullFlagN) |-> wen1N)
    else $error("write issued while a full flag is low");
  a_no_read_empty: assert property (!(&emptyFlagN) |-> ren1N)
    else $error("read issued while an empty flag is low");
  a_read_two_tied: assert property (!ren2N)
    else $error("second read enable not low");
  a_load_low_reset: assert property (!masterResetN |-> !wen2Ld)
    else $error("load pin high during master reset");
  a_flags_lockstep: assert property (fullFlagN == {NDEV{fullFlagN[0]}} &&
    emptyFlagN == {NDEV{emptyFlagN[0]}}) else $error("devices out of step");
  a_master_clear: assert property (!masterResetN |=> !emptyFlagN[0] &&
    !almostEmptyFlagN[0] && fullFlagN[0]) else $error("flags wrong after master reset");
  a_empty_leaves: assert property (masterResetN && !emptyFlagN[0] && !wen1N && wen2Ld
    |=> emptyFlagN[0]) else $error("empty flag stayed low after a write");
  a_empty_holds: assert property (masterResetN && !emptyFlagN[0] && wen1N
    |=> !emptyFlagN[0]) else $error("empty flag rose without a write");
  a_full_holds: assert property (masterResetN && !fullFlagN[0] && ren1N
    |=> !fullFlagN[0]) else $error("full flag rose without a read");
  a_almost_empty_end: assert property (!emptyFlagN[0] |-> !almostEmptyFlagN[0])
    else $error("almost-empty high while empty");
  a_almost_full_end: assert property (!fullFlagN[0] |-> !almostFullFlagN[0])
    else $error("almost-full high while full");
  a_data_held: assert property (masterResetN && ren1N |=> $stable(rdData))
    else $error("read data moved without a read");
  c_full: cover property (!fullFlagN[0]);
  c_read_full: cover property (!fullFlagN[0] && !ren1N);
  c_drained: cover property ($fell(emptyFlagN[0]) && masterResetN);
endmodule

// ### testbench/test_fifo_status_flags_width_expansion.sv
`timescale 1ns/1ps
module test_fifo_status_flags_width_expansion;
  localparam int W = fsfwe_pkg::NUM_DEV * fsfwe_pkg::DATA_W;
  localparam int DDEPTH = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic inValid = 1'b0;
  logic [W-1:0] inData = '0;
  logic outReady = 1'b0;
  logic inReady, outValid, almostEmptyN, almostFullN, running;
  logic [W-1:0] outData;
  logic [$clog2(DDEPTH):0] wc0, wc1;
  logic [W-1:0] expQ[$];
  int errors = 0;
  int cmp_count = 0;
  bit ok;
  always #5 clk = ~clk;
  fsfwe_if #(.NDEV(fsfwe_pkg::NUM_DEV)) link ();
  fsfwe_system #(.NDEV(fsfwe_pkg::NUM_DEV), .BUF_DEPTH(fsfwe_pkg::BUF_DEPTH)) fsfwe_system_i (
    .clk(clk), .rst_b(rst_b), .link(link), .inValid(inValid), .inReady(inReady),
    .inData(inData), .outValid(outValid), .outReady(outReady), .outData(outData),
    .almostEmptyN(almostEmptyN), .almostFullN(almostFullN), .running(running));
  fsfwe_device #(.DEPTH(DDEPTH), .IDX(0)) fsfwe_device_i (
    .clk(clk), .rst_b(rst_b), .link(link), .wordCount(wc0));
  fsfwe_device #(.DEPTH(DDEPTH), .IDX(1)) fsfwe_device_1_i (
    .clk(clk), .rst_b(rst_b), .link(link), .wordCount(wc1));
  fsfwe_link_props #(.NDEV(fsfwe_pkg::NUM_DEV)) fsfwe_link_props_i (
    .clk(clk), .rst_b(rst_b), .rdData(link.rdData), .wen1N(link.wen1N),
    .wen2Ld(link.wen2Ld), .ren1N(link.ren1N), .ren2N(link.ren2N),
    .masterResetN(link.masterResetN), .fullFlagN(link.fullFlagN),
    .emptyFlagN(link.emptyFlagN), .almostEmptyFlagN(link.almostEmptyFlagN),
    .almostFullFlagN(link.almostFullFlagN));

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic start();
    int n;
    n = 0;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    while (running !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      errors++;
      $display("wrong value running expected 1 seen %b", running);
      give_verdict();
    end
  endtask

  // Leaves inValid up so back-to-back words need no idle edge
  // Ready is a registered level, so its value at the falling edge is the one taken
  task automatic push(input logic [W-1:0] d, output bit took);
    int n;
    n = 0;
    took = 1'b0;
    inValid <= 1'b1;
    inData <= d;
    while (!took && n < 40) begin
      @(negedge clk);
      took = (inReady === 1'b1);
      @(posedge clk);
      n++;
    end
    if (took) expQ.push_back(d);
  endtask

  task automatic drain();
    int n;
    n = 0;
    outReady <= 1'b1;
    while (expQ.size() != 0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (n == 500) begin
      errors++;
      $display("wrong value pending expected 0 seen %0d", expQ.size());
      give_verdict();
    end
    repeat (4) @(posedge clk);
  endtask

  // Device 0 flag levels against its fill level, and device 1 fill level against device 0
  always @(negedge clk) begin
    if (rst_b && running) begin
      chk("full", 32'(wc0 != DDEPTH), 32'(link.fullFlagN[0]));
      chk("empty", 32'(wc0 != 0), 32'(link.emptyFlagN[0]));
      chk("almostEmpty", 32'(wc0 > 7), 32'(link.almostEmptyFlagN[0]));
      chk("almostFull", 32'(DDEPTH - wc0 > 7), 32'(link.almostFullFlagN[0]));
      chk("almostEmptyN", 32'(wc0 > 7), 32'(almostEmptyN));
      chk("almostFullN", 32'(DDEPTH - wc0 > 7), 32'(almostFullN));
      chk("wordCount1", 32'(wc0), 32'(wc1));
    end
  end

  always @(posedge clk) begin
    if (rst_b && outValid === 1'b1 && outReady) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("wrong value outData expected none seen %h", outData);
      end else begin
        chk("outData", 32'(expQ.pop_front()), 32'(outData));
      end
    end
  end

  initial begin
    start();
    for (int i = 0; i < 40; i++) begin
      push(W'({i[8:0], ~i[8:0]}), ok);
      if (!ok) break;
    end
    inValid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("fullAll", 32'h0, 32'(link.fullFlagN));
    chk("heldCount", 32'(DDEPTH), 32'(wc0));
    chk("inReady", 32'h0, 32'(inReady));
    @(posedge clk);
    drain();
    #1;
    chk("emptyAll", 32'h0, 32'(link.emptyFlagN));
    @(posedge clk);
    for (int i = 0; i < 6; i++) push(W'({9'h1a5, i[8:0]}), ok);
    inValid <= 1'b0;
    drain();
    outReady <= 1'b0;
    for (int i = 0; i < 3; i++) push(W'(i + 18'h2b0), ok);
    inValid <= 1'b0;
    expQ.delete();
    start();
    #1;
    chk("emptyRst", 32'h0, 32'(link.emptyFlagN));
    chk("almostEmptyRst", 32'h0, 32'(link.almostEmptyFlagN));
    chk("fullRst", 32'h3, 32'(link.fullFlagN));
    chk("countRst", 32'h0, 32'(wc0));
    @(posedge clk);
    push(W'(18'h3c1f2), ok);
    inValid <= 1'b0;
    drain();
    give_verdict();
  end
endmodule
